//--- hdl/usc_pkg.sv
// Register map, field positions and timing constants for the USB config/status block
package usc_pkg;
  // APB byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_DONE = 8'h0C;
  localparam logic [7:0] ADDR_PIPE0 = 8'h20;
  // Config fields
  localparam int CFG_EYE_BIT = 7;
  localparam int CFG_PU_BIT = 4;
  localparam int CFG_FS_BIT = 2;
  localparam logic [7:0] CFG_MASK = 8'h97;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  // Pipe control fields
  localparam int PIPE_HSK_BIT = 4;
  localparam int PIPE_SETUP_BLK_BIT = 3;
  localparam int PIPE_OUT_BIT = 2;
  localparam int PIPE_IN_BIT = 1;
  localparam int PIPE_STALL_BIT = 0;
  localparam logic [7:0] PIPE_MASK = 8'h1F;
  localparam logic [7:0] PIPE_RESET = 8'h00;
  // Pingpong modes
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_EP0_OUT = 2'h1;
  localparam logic [1:0] PP_ALL = 2'h2;
  localparam logic [1:0] PP_EP1_UP = 2'h3;
  // Status window layout
  localparam int STAT_EP_LSB = 3;
  localparam int STAT_DIR_BIT = 2;
  localparam int STAT_ODD_BIT = 1;
  // Timing: status valid after two engine clocks
  localparam int STAT_VALID_ENGINE_CLKS = 2;
  localparam int FIFO_DEPTH = 4;
  // Engine clock rates against the 250 MHz system clock
  localparam int SYS_CLK_KHZ = 250000;
  localparam int FS_CLK_KHZ = 48000;
  localparam int LS_CLK_KHZ = 6000;
  localparam int FS_DIV = SYS_CLK_KHZ / FS_CLK_KHZ;
  localparam int LS_DIV = SYS_CLK_KHZ / LS_CLK_KHZ;
  // USB handshake codes on the answer port
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_NONE = 2'h3;
endpackage

//--- hdl/usc_top.sv
// USB engine configuration, transfer status FIFO and pipe control registers
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module usc_top #(
  parameter int NUM_PIPES = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Transfer completion from the engine
  input wire logic xfer_done_i,
  input wire logic [2:0] xfer_pipe_i,
  input wire logic xfer_in_i,
  input wire logic xfer_odd_i,
  // Token request from the engine, answered next cycle
  input wire logic tok_valid_i,
  input wire logic [2:0] tok_pipe_i,
  input wire logic [1:0] tok_kind_i,
  output logic tok_ans_valid_o,
  output logic [1:0] tok_ans_o,
  // Stall issued by the engine
  input wire logic stall_set_i,
  input wire logic [2:0] stall_pipe_i,
  // Transceiver controls, engine clock enable, mode and status outputs
  output logic xcvr_full_speed_o,
  output logic pullup_dp_o,
  output logic pullup_dm_o,
  output logic eye_drive_o,
  output logic eye_dp_o,
  output logic eye_dm_o,
  output logic engine_clk_en_o,
  output logic [1:0] pingpong_mode_o,
  output logic transfer_done_flag_o,
  output logic module_enable_o
);
  // Token kinds
  localparam logic [1:0] TK_OUT = 2'h0;
  localparam logic [1:0] TK_IN = 2'h1;
  localparam logic [1:0] TK_SETUP = 2'h2;

  logic rst_s1_ff, rst_n_ff;
  logic [7:0] cfg_ff;
  logic en_ff;
  logic [7:0] pipe_ff [NUM_PIPES];
  logic [4:0] fifo_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] rd_ptr_ff, wr_ptr_ff;
  logic [$clog2(DEPTH):0] cnt_ff;
  logic [5:0] div_ff;
  logic tick;
  logic [1:0] settle_ff;
  logic flag_ff;
  logic eye_phase_ff;
  // Write strobe, FIFO push/pop, full state and flag-clear request
  logic wr_acc, push, pop, full, clr_flag;
  // Read data captured in the setup cycle
  logic [31:0] nxt_rdata;

  // Reset release through two flops
  // Entry is immediate; release waits two edges so no flop sees a runt
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // Zero-wait APB: every access completes in its access cycle
  assign wr_acc = psel_i && penable_i && pwrite_i;

  // Decodes the pipe register hit and index; the index comes from the offset even with hit low
  function automatic logic pipe_hit(input logic [7:0] a);
    pipe_hit = (a >= usc_pkg::ADDR_PIPE0) && (a < usc_pkg::ADDR_PIPE0 + 8'(4 * NUM_PIPES))
      && (a[1:0] == 2'h0);
  endfunction
  function automatic logic [2:0] pipe_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - usc_pkg::ADDR_PIPE0;
    pipe_idx = d[4:2];
  endfunction
  // Any mapped register; unmapped accesses answer with an error
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == usc_pkg::ADDR_CONFIG) || (a == usc_pkg::ADDR_STATUS)
      || (a == usc_pkg::ADDR_CTRL) || (a == usc_pkg::ADDR_DONE) || pipe_hit(a);
  endfunction

  // Configuration register; speed and pull-up frozen while enabled
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cfg_ff <= usc_pkg::CFG_RESET;
    end else if (wr_acc && paddr_i == usc_pkg::ADDR_CONFIG) begin
      cfg_ff[usc_pkg::CFG_EYE_BIT] <= pwdata_i[usc_pkg::CFG_EYE_BIT];
      cfg_ff[1:0] <= pwdata_i[1:0];
      // Guard against a live speed change, which firmware must never do
      if (!en_ff) begin
        cfg_ff[usc_pkg::CFG_PU_BIT] <= pwdata_i[usc_pkg::CFG_PU_BIT];
        cfg_ff[usc_pkg::CFG_FS_BIT] <= pwdata_i[usc_pkg::CFG_FS_BIT];
      end
    end
  end

  // Main enable bit
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      en_ff <= 1'b0;
    end else if (wr_acc && paddr_i == usc_pkg::ADDR_CTRL) begin
      en_ff <= pwdata_i[usc_pkg::CTRL_EN_BIT];
    end
  end

  // Eight pipe control registers; engine stall wins over firmware write
  // Bits 7-5 are masked on write so they always read as zero
  genvar g;
  generate
    for (g = 0; g < NUM_PIPES; g++) begin : g_pipe
      always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          pipe_ff[g] <= usc_pkg::PIPE_RESET;
        end else begin
          if (wr_acc && pipe_hit(paddr_i) && pipe_idx(paddr_i) == 3'(g)) begin
            pipe_ff[g] <= pwdata_i[7:0] & usc_pkg::PIPE_MASK;
          end
          if (en_ff && stall_set_i && stall_pipe_i == 3'(g)) begin
            pipe_ff[g][usc_pkg::PIPE_STALL_BIT] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Engine clock enable: 50 MHz or about 6.1 MHz rate from the divider
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      div_ff <= '0;
    end else if (tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 6'h01;
    end
  end
  // Integer dividers run the engine a little fast (50 and about 6.1 MHz)
  assign tick = cfg_ff[usc_pkg::CFG_FS_BIT] ? (div_ff >= 6'(usc_pkg::FS_DIV - 1))
    : (div_ff >= 6'(usc_pkg::LS_DIV - 1));

  // Status FIFO: push on completion, pop when firmware clears the flag
  // A completion while full is lost; the token path answers NAK meanwhile
  assign full = (cnt_ff == ($clog2(DEPTH)+1)'(DEPTH));
  assign push = en_ff && xfer_done_i && !full;
  assign clr_flag = wr_acc && paddr_i == usc_pkg::ADDR_DONE && pwdata_i[0];
  // Clearing an already clear flag pops nothing
  assign pop = clr_flag && flag_ff && cnt_ff != '0;
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (!en_ff) begin
      // Disabled module drops queued statuses
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      // Storage words need no reset: the count says which are valid
      if (push) begin
        fifo_ff[wr_ptr_ff] <= {xfer_pipe_i, xfer_in_i, xfer_odd_i};
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // Flag rises once the head has settled for two engine clocks
  // A pop restarts the count, so a queued entry is flagged afresh
  // At low speed the two ticks take about 80 system cycles
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      settle_ff <= '0;
      flag_ff <= 1'b0;
    end else if (!en_ff || pop || cnt_ff == '0) begin
      settle_ff <= '0;
      flag_ff <= 1'b0;
    end else if (!flag_ff && tick) begin
      // Raising late keeps the window stable when firmware sees the flag
      if (settle_ff == 2'(usc_pkg::STAT_VALID_ENGINE_CLKS - 1)) begin
        flag_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + 2'h1;
      end
    end
  end

  // Token answers: NAK when FIFO full, stall, handshake control
  // SETUP follows the OUT enable unless IN, OUT and setup-block bits are all set; stall counts only on an enabled pipe
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tok_ans_valid_o <= 1'b0;
      tok_ans_o <= usc_pkg::HS_NONE;
    end else begin
      tok_ans_valid_o <= tok_valid_i && en_ff;
      if (tok_valid_i) begin
        logic [7:0] p;
        logic dir_en;
        p = pipe_ff[tok_pipe_i];
        dir_en = (tok_kind_i == TK_IN) ? p[usc_pkg::PIPE_IN_BIT] : p[usc_pkg::PIPE_OUT_BIT];
        if (tok_kind_i == TK_SETUP && p[usc_pkg::PIPE_IN_BIT] && p[usc_pkg::PIPE_OUT_BIT]
            && p[usc_pkg::PIPE_SETUP_BLK_BIT]) begin
          dir_en = 1'b0;
        end
        if (!dir_en || !p[usc_pkg::PIPE_HSK_BIT]) begin
          tok_ans_o <= usc_pkg::HS_NONE;
        end else if (p[usc_pkg::PIPE_STALL_BIT]) begin
          tok_ans_o <= usc_pkg::HS_STALL;
        end else if (full) begin
          tok_ans_o <= usc_pkg::HS_NAK;
        end else begin
          tok_ans_o <= usc_pkg::HS_ACK;
        end
      end
    end
  end

  // Eye pattern: J/K toggles each engine bit time, starting K at full speed
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      eye_phase_ff <= 1'b0;
      eye_drive_o <= 1'b0;
      eye_dp_o <= 1'b0;
      eye_dm_o <= 1'b0;
    end else begin
      eye_drive_o <= en_ff && cfg_ff[usc_pkg::CFG_EYE_BIT];
      if (!(en_ff && cfg_ff[usc_pkg::CFG_EYE_BIT])) begin
        eye_phase_ff <= 1'b0;
      end else if (tick) begin
        eye_phase_ff <= ~eye_phase_ff;
      end
      // J is D+ high at full speed, D- high at low speed; phase 0 is K at FS, J at LS
      // Both mean D- high, so phase 0 drives D- at either speed
      eye_dp_o <= eye_phase_ff;
      eye_dm_o <= ~eye_phase_ff;
    end
  end

  // Transceiver and mode outputs; pull-ups and engine clock enable gated by module enable
  // Speed is frozen while enabled, so the pull-up never hops lines
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xcvr_full_speed_o <= 1'b0;
      pullup_dp_o <= 1'b0;
      pullup_dm_o <= 1'b0;
      engine_clk_en_o <= 1'b0;
      pingpong_mode_o <= usc_pkg::PP_NONE;
      transfer_done_flag_o <= 1'b0;
      module_enable_o <= 1'b0;
    end else begin
      xcvr_full_speed_o <= cfg_ff[usc_pkg::CFG_FS_BIT];
      pullup_dp_o <= en_ff && cfg_ff[usc_pkg::CFG_PU_BIT] && cfg_ff[usc_pkg::CFG_FS_BIT];
      pullup_dm_o <= en_ff && cfg_ff[usc_pkg::CFG_PU_BIT] && !cfg_ff[usc_pkg::CFG_FS_BIT];
      engine_clk_en_o <= en_ff && tick;
      pingpong_mode_o <= cfg_ff[1:0];
      transfer_done_flag_o <= flag_ff;
      module_enable_o <= en_ff;
    end
  end

  // Read mux
  // An empty FIFO shows a stale head, which firmware must not trust
  always_comb begin
    logic [4:0] h;
    nxt_rdata = 32'h0000_0000;
    h = fifo_ff[rd_ptr_ff];
    if (paddr_i == usc_pkg::ADDR_CONFIG) begin
      nxt_rdata[7:0] = cfg_ff & usc_pkg::CFG_MASK;
    end else if (paddr_i == usc_pkg::ADDR_STATUS) begin
      nxt_rdata[5:1] = h;
    end else if (paddr_i == usc_pkg::ADDR_CTRL) begin
      nxt_rdata[usc_pkg::CTRL_EN_BIT] = en_ff;
    end else if (paddr_i == usc_pkg::ADDR_DONE) begin
      nxt_rdata[0] = flag_ff;
    end else if (pipe_hit(paddr_i)) begin
      nxt_rdata[7:0] = pipe_ff[pipe_idx(paddr_i)];
    end
  end

  // APB answer registered; pready rises in the access cycle's setup-next flop
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      // Unmapped addresses read zero and answer with an error
      if (psel_i && !penable_i) begin
        prdata_o <= nxt_rdata;
        pslverr_o <= !reg_mapped(paddr_i);
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end
endmodule

//--- verification/usc_checker.sv
// Port-level assertions for the USB config/status block
`timescale 1ns/1ps
module usc_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  // Engine side
  input wire logic xfer_done_i,
  input wire logic tok_valid_i,
  input wire logic tok_ans_valid_o,
  input wire logic [1:0] tok_ans_o,
  // Transceiver and status
  input wire logic xcvr_full_speed_o,
  input wire logic pullup_dp_o,
  input wire logic pullup_dm_o,
  input wire logic eye_drive_o,
  input wire logic eye_dp_o,
  input wire logic eye_dm_o,
  input wire logic engine_clk_en_o,
  input wire logic transfer_done_flag_o,
  input wire logic module_enable_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Any write, delayed: a flag clear may land one cycle late
  logic wr_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff <= 1'b0;
    end else begin
      wr_ff <= psel_i && penable_i && pwrite_i;
    end
  end
  property p_ans;
    tok_ans_valid_o == ($past(tok_valid_i) && module_enable_o);
  endproperty
  a_ans: assert property (p_ans) else $error("token not answered");
  property p_pu_side;
    pullup_dp_o || pullup_dm_o |-> pullup_dp_o == xcvr_full_speed_o && pullup_dm_o != pullup_dp_o;
  endproperty
  a_pu_side: assert property (p_pu_side) else $error("pull-up on wrong line");
  property p_pu_off;
    !module_enable_o && !$past(module_enable_o) |-> !pullup_dp_o && !pullup_dm_o;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up while disabled");
  property p_eye;
    eye_drive_o |-> eye_dp_o != eye_dm_o;
  endproperty
  a_eye: assert property (p_eye) else $error("eye pattern not differential");
  property p_eye_start;
    $rose(eye_drive_o) |-> !eye_dp_o && eye_dm_o;
  endproperty
  a_eye_start: assert property (p_eye_start) else $error("eye pattern wrong first symbol");
  property p_rate;
    engine_clk_en_o && xcvr_full_speed_o |=> !engine_clk_en_o [*4];
  endproperty
  a_rate: assert property (p_rate) else $error("engine tick too soon");
  property p_flag_rise;
    xfer_done_i && module_enable_o |-> ##[1:150] transfer_done_flag_o;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag never raised");
  property p_flag_hold;
    transfer_done_flag_o && module_enable_o && !wr_ff && !(psel_i && penable_i && pwrite_i)
      |=> transfer_done_flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped uncleared");
  property p_stat_zero;
    psel_i && penable_i && pready_o && !pwrite_i && paddr_i == usc_pkg::ADDR_STATUS
      |-> prdata_o[7:6] == 2'h0 && !prdata_o[0];
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("status spare bits set");
  c_nak: cover property (tok_ans_valid_o && tok_ans_o == usc_pkg::HS_NAK);
  c_eye: cover property ($rose(eye_drive_o));
  c_flag: cover property ($rose(transfer_done_flag_o));
endmodule
bind usc_top usc_checker u_chk (.*);

//--- verification/usc_engine_model.sv
// Engine-side model: completions, token requests and stall events
`timescale 1ns/1ps
module usc_engine_model (
  // Clock
  input wire logic ref_clk_i,
  // Completions and stalls
  output logic xfer_done_o,
  output logic [2:0] xfer_pipe_o,
  output logic xfer_in_o,
  output logic xfer_odd_o,
  output logic stall_set_o,
  output logic [2:0] stall_pipe_o,
  // Tokens
  output logic tok_valid_o,
  output logic [2:0] tok_pipe_o,
  output logic [1:0] tok_kind_o,
  input wire logic tok_ans_valid_i,
  input wire logic [1:0] tok_ans_i
);
  initial begin
    {xfer_done_o, xfer_pipe_o, xfer_in_o, xfer_odd_o} = 6'h0;
    {stall_set_o, stall_pipe_o, tok_valid_o, tok_pipe_o, tok_kind_o} = 10'h0;
  end
  // Fields inverted after each pulse so stale values never pass
  task automatic send_xfer(input logic [2:0] p, input logic i, input logic o);
    @(posedge ref_clk_i);
    xfer_done_o <= 1'b1;
    {xfer_pipe_o, xfer_in_o, xfer_odd_o} <= {p, i, o};
    @(posedge ref_clk_i);
    xfer_done_o <= 1'b0;
    {xfer_pipe_o, xfer_in_o, xfer_odd_o} <= ~{p, i, o};
  endtask
  task automatic send_stall(input logic [2:0] p);
    @(posedge ref_clk_i);
    stall_set_o <= 1'b1;
    stall_pipe_o <= p;
    @(posedge ref_clk_i);
    stall_set_o <= 1'b0;
    stall_pipe_o <= ~p;
  endtask
  // Answer arrives one cycle after the token is taken
  task automatic send_tok(input logic [2:0] p, input logic [1:0] k, output logic [2:0] a);
    @(posedge ref_clk_i);
    tok_valid_o <= 1'b1;
    {tok_pipe_o, tok_kind_o} <= {p, k};
    @(posedge ref_clk_i);
    tok_valid_o <= 1'b0;
    {tok_pipe_o, tok_kind_o} <= ~{p, k};
    @(posedge ref_clk_i);
    a = {tok_ans_valid_i, tok_ans_i};
  endtask
endmodule

//--- verification/usc_top_tb.sv
// Self-checking bench for the USB config/status block
`timescale 1ns/1ps
module usc_top_tb;
  logic ref_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, seed, ctl [8];
  logic xfer_done_i, xfer_in_i, xfer_odd_i, tok_valid_i, tok_ans_valid_o, stall_set_i;
  logic [2:0] xfer_pipe_i, tok_pipe_i, stall_pipe_i, ans;
  logic [1:0] tok_kind_i, tok_ans_o, pingpong_mode_o;
  logic xcvr_full_speed_o, pullup_dp_o, pullup_dm_o, eye_drive_o, eye_dp_o, eye_dm_o;
  logic engine_clk_en_o, transfer_done_flag_o, module_enable_o;
  logic [4:0] q [$];
  int n_mismatch, num_checks, k, n_tog;
  usc_top dut (.*);
  usc_engine_model eng (.ref_clk_i(ref_clk_i), .xfer_done_o(xfer_done_i),
    .xfer_pipe_o(xfer_pipe_i), .xfer_in_o(xfer_in_i), .xfer_odd_o(xfer_odd_i),
    .stall_set_o(stall_set_i), .stall_pipe_o(stall_pipe_i), .tok_valid_o(tok_valid_i),
    .tok_pipe_o(tok_pipe_i), .tok_kind_o(tok_kind_i), .tok_ans_valid_i(tok_ans_valid_o),
    .tok_ans_i(tok_ans_o));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected answer, highest priority first
  function automatic logic [2:0] exp_ans(input logic [7:0] c, input logic [1:0] kd, input logic f);
    if (!(kd == 2'h1 ? c[1] : c[2]) || (kd == 2'h2 && c[3:1] == 3'h7) || !c[4]) begin
      return {1'b1, usc_pkg::HS_NONE};
    end
    if (c[0]) return {1'b1, usc_pkg::HS_STALL};
    return {1'b1, f ? usc_pkg::HS_NAK : usc_pkg::HS_ACK};
  endfunction
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t reg got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_ans(input logic [2:0] g, input logic [2:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t answer got %h exp %h", $time, g, e);
    end
  endtask
  // APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 44'h0;
    seed = 32'hAB249FDE;
    repeat (6) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    apb(1'b0, usc_pkg::ADDR_CONFIG, 32'h0);
    chk_reg(rd, {24'h0, usc_pkg::CFG_RESET});
    // Pipe reset values, then settings read back masked: fixed for pipes 0 and 1, random for the rest
    for (k = 0; k < 8; k++) begin
      apb(1'b0, usc_pkg::ADDR_PIPE0 + 8'(4 * k), 32'h0);
      chk_reg(rd, {24'h0, usc_pkg::PIPE_RESET});
      seed = lfsr(seed);
      ctl[k] = seed & {24'h0, usc_pkg::PIPE_MASK};
      apb(1'b1, usc_pkg::ADDR_PIPE0 + 8'(4 * k), k < 2 ? 32'h1E - 32'(8 * k) : seed);
      if (k < 2) ctl[k] = 32'h1E - 32'(8 * k);
      apb(1'b0, usc_pkg::ADDR_PIPE0 + 8'(4 * k), 32'h0);
      chk_reg(rd, ctl[k]);
    end
    apb(1'b0, 8'h10, 32'h0);
    chk_reg({rd[30:0], err}, 32'h1);
    // Every buffering mode at both speeds; eye bit kept off before enable
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      apb(1'b1, usc_pkg::ADDR_CONFIG, {seed[31:8], 1'b0, seed[6:3], k[2:0]});
      apb(1'b0, usc_pkg::ADDR_CONFIG, 32'h0);
      chk_reg(rd, {27'h0, seed[4], 1'b0, k[2:0]});
      chk_reg({29'h0, xcvr_full_speed_o, pingpong_mode_o}, {29'h0, k[2:0]});
      apb(1'b1, usc_pkg::ADDR_CTRL, 32'h1);
      repeat (2) @(posedge ref_clk_i);
      chk_reg({pullup_dp_o, pullup_dm_o}, {seed[4] & k[2], seed[4] & !k[2]});
      apb(1'b1, usc_pkg::ADDR_CTRL, 32'h0);
    end
    apb(1'b1, usc_pkg::ADDR_CONFIG, 32'h14);
    apb(1'b1, usc_pkg::ADDR_CTRL, 32'h1);
    for (k = 0; k < 24; k++) begin
      eng.send_tok(3'(k / 3), 2'(k % 3), ans);
      chk_ans(ans, exp_ans(ctl[k / 3][7:0], 2'(k % 3), 1'b0));
    end
    eng.send_stall(3'h1);
    apb(1'b0, usc_pkg::ADDR_PIPE0 + 8'h4, 32'h0);
    chk_reg(rd, 32'h17);
    apb(1'b1, usc_pkg::ADDR_PIPE0 + 8'h4, 32'h16);
    // Five completions: four queue, the fifth is dropped
    for (k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      if (k < 4) q.push_back(seed[4:0]);
      eng.send_xfer(seed[4:2], seed[1], seed[0]);
    end
    eng.send_tok(3'h1, 2'h0, ans);
    chk_ans(ans, exp_ans(8'h16, 2'h0, 1'b1));
    while (q.size() > 0) begin
      for (k = 0; k < 60 && transfer_done_flag_o !== 1'b1; k++) @(posedge ref_clk_i);
      repeat (12) @(posedge ref_clk_i);
      apb(1'b0, usc_pkg::ADDR_STATUS, 32'h0);
      chk_reg(rd, {26'h0, q.pop_front(), 1'b0});
      apb(1'b0, usc_pkg::ADDR_DONE, 32'h0);
      chk_reg(rd, 32'h1);
      apb(1'b1, usc_pkg::ADDR_DONE, 32'h1);
      repeat (2) @(posedge ref_clk_i);
    end
    repeat (60) @(posedge ref_clk_i);
    apb(1'b0, usc_pkg::ADDR_DONE, 32'h0);
    chk_reg(rd, 32'h0);
    // Eye pattern: starts on K at full speed, then one toggle per engine tick
    apb(1'b1, usc_pkg::ADDR_CONFIG, 32'h94);
    repeat (2) @(posedge ref_clk_i);
    chk_reg({29'h0, eye_drive_o, eye_dp_o, eye_dm_o}, 32'h5);
    repeat (2) @(posedge ref_clk_i);
    n_tog = 0;
    for (k = 0; k < 50; k++) begin
      err = eye_dp_o;
      @(posedge ref_clk_i);
      n_tog += int'(err !== eye_dp_o);
    end
    chk_reg({eye_drive_o, 1'(n_tog > 8 && n_tog < 12)}, 32'h3);
    apb(1'b1, usc_pkg::ADDR_CONFIG, 32'h14);
    repeat (4) @(posedge ref_clk_i);
    chk_reg({31'h0, eye_drive_o}, 32'h0);
    // Low speed eye pattern starts on J, which is D- high
    apb(1'b1, usc_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, usc_pkg::ADDR_CONFIG, 32'h10);
    apb(1'b1, usc_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, usc_pkg::ADDR_CONFIG, 32'h90);
    repeat (2) @(posedge ref_clk_i);
    chk_reg({29'h0, eye_drive_o, eye_dp_o, eye_dm_o}, 32'h5);
    // Disabled module ignores completions
    apb(1'b1, usc_pkg::ADDR_CTRL, 32'h0);
    eng.send_xfer(3'h2, 1'b1, 1'b0);
    repeat (60) @(posedge ref_clk_i);
    chk_reg({31'h0, transfer_done_flag_o}, 32'h0);
    tally_and_finish();
  end
endmodule
